// ==== core/paged_dual_down_counter.sv ====
// Paged dual down-counter: a 24-bit and a 16-bit counter behind a
// byte-wide register window (staging bytes plus a command register).
// Assumes the host drives busReq on mclk and the page bit as a level;
// count pulses and gates arrive asynchronously on pins.
//
// Notes on behaviour
// - Low staging write fills a hidden load byte, counter untouched.
// - Staging byte reads return last latched byte, not written value.
// - Byte at 13 is counter 1 high, counter 0 middle byte.
// - Counter 0 is 24 bits, counter 1 is 16; byte 14 counter 0 only.
// - Loading counter 1 ignores staging byte 14.
// - Command bit 7 selects counter; set bits run, but clear beats load, gate-off beats gate-on, stop beats run.
// - Latch copies counter into readback; read low, middle, high.
// - Counter 1 latch leaves readback byte 14 from counter 0.
// - With gating on, counting only while that gate is high.
// - Gate-off makes counting independent of the gate level.
// - Count-run makes counter decrement once per input pulse.
// - Count-stop makes counter ignore pulses and hold.
// - Load moves staged bytes in: three for 0, two for 1.
// - Clear sets selected counter to zero at once.
// - Staging bytes are independent and written in any order.
module paged_dual_down_counter
  import pdc_pkg::*;
#(
  parameter int CNT0_W = CNT0_W_DEF,
  parameter int CNT1_W = CNT1_W_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        pageSel,
  input  wire bus_req_t    busReq,
  output logic      [7:0]  rdData,
  input  wire logic [1:0]  countPulse,
  input  wire logic        externalGateFirst,
  input  wire logic        externalGateSecond,
  output logic      [23:0] count0Value,
  output logic      [15:0] count1Value
);

  // Widths beyond the byte lanes cannot be staged or latched
  if (CNT0_W < 17 || CNT0_W > MAX_W) begin : g_chk0
    $error("CNT0_W must lie in 17..24");
  end
  if (CNT1_W < 9 || CNT1_W > 16) begin : g_chk1
    $error("CNT1_W must lie in 9..16");
  end

  // Keep a value within the width of counter idx
  function automatic logic [23:0] clip(input logic [23:0] v,
                                       input logic        idx);
    logic [23:0] m;
    m = idx ? ((24'h00_0001 << CNT1_W) - 24'h00_0001)
            : ((24'h00_0001 << CNT0_W) - 24'h00_0001);
    return v & m;
  endfunction

  // Staging byte index for offsets 12..14
  function automatic logic [1:0] byteIdx(input logic [3:0] a);
    logic [3:0] d;
    d = a - OFF_BYTE_LOW;
    return d[1:0];
  endfunction

  logic [1:0]  pulseRise;
  logic [1:0]  gateLevelSync;
  logic        pageHit;
  logic        stageWr;
  logic        cmdWr;
  logic [7:0]  cmd;
  logic        cmdSel;
  logic [1:0]  tick;
  logic [23:0] staged;
  logic [7:0]  stageQ [3];
  logic [7:0]  latchQ [3];
  logic [23:0] ctrQ   [2];
  ctr_ctl_t    ctlQ   [2];
  logic [7:0]  rdDataQ;

  // Pulses cross into mclk through three stages each; only their
  // rising edges matter, so the filtered level is left open
  pin_sync3 #(.W(2)) u_pulseSync (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .pinIn (countPulse),
    .level (),
    .rise  (pulseRise)
  );

  // Gates only matter as levels
  pin_sync3 #(.W(2)) u_gateSync (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .pinIn ({externalGateSecond, externalGateFirst}),
    .level (gateLevelSync),
    .rise  ()
  );

  // Window decode; page 1 belongs to calibration logic elsewhere
  assign pageHit = (pageSel == PAGE_COUNTER);
  assign stageWr = ce & busReq.wr & pageHit &
                   (busReq.addr >= OFF_BYTE_LOW) &
                   (busReq.addr <= OFF_BYTE_HIGH);
  assign cmdWr   = ce & busReq.wr & pageHit &
                   (busReq.addr == OFF_COMMAND);
  assign cmd     = busReq.data;
  assign cmdSel  = cmd[BIT_COUNTER_SELECT];
  assign staged  = {stageQ[2], stageQ[1], stageQ[0]};

  // Staging bytes; each write touches only its own byte
  // Nothing here reaches a counter until a load command
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < 3; b++) begin
        stageQ[b] <= BYTE_RESET;
      end
    end else if (stageWr) begin
      stageQ[byteIdx(busReq.addr)] <= busReq.data;
    end
  end

  // Counting qualified by run flag and, if enabled, the gate
  // Gate is the synchronised level, so it lags the pin by four cycles
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tick[i] = pulseRise[i] & ctlQ[i].countRun &
                (~ctlQ[i].gateOn | gateLevelSync[i]);
    end
  end

  // Per-counter control flags and value; clear and load beat pulses
  for (genvar i = 0; i < 2; i++) begin : g_ctr
    logic hitCmd;
    assign hitCmd = cmdWr & (cmdSel == 1'(i));

    // Each operation bit acts alone; others are left alone
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ctlQ[i] <= CTL_RESET;
      end else if (hitCmd) begin
        if (cmd[BIT_GATE_ON_CMD]) begin
          ctlQ[i].gateOn <= 1'b1;
        end
        if (cmd[BIT_GATE_OFF_CMD]) begin
          ctlQ[i].gateOn <= 1'b0;
        end
        if (cmd[BIT_COUNT_RUN_CMD]) begin
          ctlQ[i].countRun <= 1'b1;
        end
        if (cmd[BIT_COUNT_STOP_CMD]) begin
          ctlQ[i].countRun <= 1'b0;
        end
      end
    end

    // Clear outranks load, load outranks a pulse in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ctrQ[i] <= COUNT_RESET;
      end else if (ce) begin
        if (hitCmd && cmd[BIT_ZERO_CMD]) begin
          ctrQ[i] <= COUNT_RESET;
        end else if (hitCmd && cmd[BIT_LOAD_CMD]) begin
          ctrQ[i] <= clip(staged, 1'(i));
        end else if (tick[i]) begin
          ctrQ[i] <= clip(ctrQ[i] - 24'h00_0001, 1'(i));
        end
      end
    end
  end

  // Latch snapshot; counter 1 leaves the high byte alone, so byte 14
  // still shows the last counter 0 snapshot afterwards
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < 3; b++) begin
        latchQ[b] <= BYTE_RESET;
      end
    end else if (cmdWr && cmd[BIT_LATCH_CMD]) begin
      latchQ[0] <= ctrQ[cmdSel][7:0];
      latchQ[1] <= ctrQ[cmdSel][15:8];
      if (!cmdSel) begin
        latchQ[2] <= ctrQ[0][23:16];
      end
    end
  end

  // Registered read data; holds until the next read
  // Offset 15 and page 1 read as fill; the command register is write-only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdDataQ <= READ_FILL;
    end else if (ce && busReq.rd) begin
      if (pageHit && busReq.addr >= OFF_BYTE_LOW &&
          busReq.addr <= OFF_BYTE_HIGH) begin
        rdDataQ <= latchQ[byteIdx(busReq.addr)];
      end else begin
        rdDataQ <= READ_FILL;
      end
    end
  end

  assign rdData      = rdDataQ;
  assign count0Value = ctrQ[0];
  assign count1Value = ctrQ[1][15:0];

  // Checks on the logic above
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic isLoad1;
  logic isLoad0;
  logic isLatch1;
  logic isLatch0;
  assign isLoad0  = cmdWr && cmd == 8'h02;
  assign isLoad1  = cmdWr && cmd == 8'h82;
  assign isLatch1 = cmdWr && cmd == 8'hC0;
  assign isLatch0 = cmdWr && cmd == 8'h40;

  a_stage_low_store: assert property (
    stageWr && busReq.addr == OFF_BYTE_LOW |=>
      stageQ[0] == $past(busReq.data) && ctrQ[0] == $past(ctrQ[0])
      || $past(tick[0]))
    else $error("low staging byte not stored");
  a_read_latched: assert property (
    ce && busReq.rd && pageHit && busReq.addr == OFF_BYTE_MID |=>
      rdData == $past(latchQ[1]))
    else $error("read did not return latched byte");
  a_width_ctr1: assert property (
    ctrQ[1][23:16] == 8'h00)
    else $error("counter 1 exceeds 16 bits");
  a_load_ctr1: assert property (
    isLoad1 |=> ctrQ[1] == {8'h00, $past(stageQ[1]), $past(stageQ[0])})
    else $error("counter 1 load wrong");
  a_load_ctr0: assert property (
    isLoad0 |=> ctrQ[0] == $past(staged))
    else $error("counter 0 load wrong");
  a_latch_keep_hi: assert property (
    isLatch1 |=> latchQ[2] == $past(latchQ[2]) &&
                 latchQ[0] == $past(ctrQ[1][7:0]))
    else $error("counter 1 latch disturbed high byte");
  a_gate_blocks: assert property (
    ce && !cmdWr && ctlQ[0].gateOn && !gateLevelSync[0] |=>
      $stable(ctrQ[0]))
    else $error("counted with gate low");
  a_tick_decr: assert property (
    ce && tick[1] && !cmdWr |=>
      ctrQ[1] == clip($past(ctrQ[1]) - 24'h00_0001, 1'b1))
    else $error("pulse did not decrement");
  a_stop_holds: assert property (
    ce && !cmdWr && !ctlQ[0].countRun [*2] |-> $stable(ctrQ[0]))
    else $error("stopped counter moved");
  a_clear_zero: assert property (
    cmdWr && cmd == 8'h81 |=> ctrQ[1] == COUNT_RESET)
    else $error("clear did not zero");
  a_page_hide: assert property (
    ce && busReq.rd && !pageHit |=> rdData == READ_FILL)
    else $error("counter map leaked onto page 1");

  // Byte lanes and latch snapshots, per counter
  a_latch_ctr0: assert property (
    isLatch0 |=> latchQ[0] == $past(ctrQ[0][7:0]) &&
                 latchQ[1] == $past(ctrQ[0][15:8]) &&
                 latchQ[2] == $past(ctrQ[0][23:16]))
    else $error("counter 0 latch wrong");
  a_latch_mid1: assert property (
    isLatch1 |=> latchQ[1] == $past(ctrQ[1][15:8]))
    else $error("counter 1 high byte not latched");
  a_read_low: assert property (
    ce && busReq.rd && pageHit && busReq.addr == OFF_BYTE_LOW |=>
      rdData == $past(latchQ[0]))
    else $error("low read did not return latched byte");
  a_read_high: assert property (
    ce && busReq.rd && pageHit && busReq.addr == OFF_BYTE_HIGH |=>
      rdData == $past(latchQ[2]))
    else $error("high read did not return latched byte");
  a_stage_mid: assert property (
    stageWr && busReq.addr == OFF_BYTE_MID |=>
      stageQ[1] == $past(busReq.data) &&
      stageQ[0] == $past(stageQ[0]) && stageQ[2] == $past(stageQ[2]))
    else $error("middle staging write disturbed another byte");
  a_stage_high: assert property (
    stageWr && busReq.addr == OFF_BYTE_HIGH |=>
      stageQ[2] == $past(busReq.data) &&
      stageQ[0] == $past(stageQ[0]) && stageQ[1] == $past(stageQ[1]))
    else $error("high staging write disturbed another byte");

  // Command flags: each bit acts on the selected counter only
  a_gate_on: assert property (
    cmdWr && cmd == 8'h10 |=> ctlQ[0].gateOn)
    else $error("gate-on did not take");
  a_gate_off: assert property (
    cmdWr && cmd == 8'h20 |=> !ctlQ[0].gateOn)
    else $error("gate-off did not take");
  a_run_set: assert property (
    cmdWr && cmd == 8'h84 |=> ctlQ[1].countRun)
    else $error("count-run did not take");
  a_stop_set: assert property (
    cmdWr && cmd == 8'h08 |=> !ctlQ[0].countRun)
    else $error("count-stop did not take");
  a_other_ctr: assert property (
    cmdWr && !cmdSel |=> ctlQ[1] == $past(ctlQ[1]))
    else $error("command touched the other counter");
  a_clear_ctr0: assert property (
    cmdWr && cmd == 8'h01 |=> ctrQ[0] == COUNT_RESET)
    else $error("clear did not zero counter 0");
  a_gate_free: assert property (
    ce && !cmdWr && !ctlQ[1].gateOn && ctlQ[1].countRun &&
      pulseRise[1] |=> ctrQ[1] != $past(ctrQ[1]))
    else $error("ungated counter ignored a pulse");
  a_tick_ctr0: assert property (
    ce && tick[0] && !cmdWr |=>
      ctrQ[0] == clip($past(ctrQ[0]) - 24'h00_0001, 1'b0))
    else $error("pulse did not decrement counter 0");

  // Page 1 writes and a low enable leave all state alone
  a_page_stage: assert property (
    busReq.wr && !pageHit |=>
      stageQ[0] == $past(stageQ[0]) && stageQ[1] == $past(stageQ[1]) &&
      stageQ[2] == $past(stageQ[2]))
    else $error("page 1 write reached staging");
  a_page_cmd: assert property (
    busReq.wr && !pageHit |=>
      ctlQ[0] == $past(ctlQ[0]) && ctlQ[1] == $past(ctlQ[1]))
    else $error("page 1 write reached command flags");
  a_ce_freeze: assert property (
    !ce |=> $stable(ctrQ[0]) && $stable(ctrQ[1]) && $stable(rdData))
    else $error("state moved with enable low");
  a_read_hold: assert property (
    !(ce && busReq.rd) |=> $stable(rdData))
    else $error("read data changed without a read");

  c_load_then_count: cover property (isLoad0 ##[1:50] tick[0]);
  c_latch_read: cover property (isLatch1 ##[1:5] busReq.rd);
  c_gate_hold: cover property (ctlQ[1].gateOn && !gateLevelSync[1]
                               && pulseRise[1]);
  c_wrap_ctr1: cover property (tick[1] && ctrQ[1] == COUNT_RESET);
  c_hidden_write: cover property (busReq.wr && !pageHit);

endmodule

// ==== core/pdc_pkg.sv ====
// Constants and carrier types for the paged dual down-counter.
// Assumes a byte-wide register port with a 4-bit offset on one clock.
package pdc_pkg;

  // Register offsets within the page window
  localparam logic [3:0] OFF_BYTE_LOW  = 4'hC;
  localparam logic [3:0] OFF_BYTE_MID  = 4'hD;
  localparam logic [3:0] OFF_BYTE_HIGH = 4'hE;
  localparam logic [3:0] OFF_COMMAND   = 4'hF;

  // Page that shows the counter map
  localparam logic PAGE_COUNTER = 1'b0;

  // Command register field positions
  localparam int BIT_COUNTER_SELECT = 7;
  localparam int BIT_LATCH_CMD      = 6;
  localparam int BIT_GATE_OFF_CMD   = 5;
  localparam int BIT_GATE_ON_CMD    = 4;
  localparam int BIT_COUNT_STOP_CMD = 3;
  localparam int BIT_COUNT_RUN_CMD  = 2;
  localparam int BIT_LOAD_CMD       = 1;
  localparam int BIT_ZERO_CMD       = 0;

  // Widths and reset values
  localparam int         MAX_W        = 24;
  localparam int         CNT0_W_DEF   = 24;
  localparam int         CNT1_W_DEF   = 16;
  localparam int         SYNC_STAGES  = 3;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [7:0] READ_FILL    = 8'h00;
  localparam logic [23:0] COUNT_RESET = 24'h00_0000;

  // One register access on the byte port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] data;
  } bus_req_t;

  // Per-counter control flags
  typedef struct packed {
    logic gateOn;
    logic countRun;
  } ctr_ctl_t;

  localparam ctr_ctl_t CTL_RESET = '{gateOn: 1'b0, countRun: 1'b0};

endpackage

// ==== core/pin_sync3.sv ====
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes pins are asynchronous to mclk; ce freezes every stage.
module pin_sync3
  import pdc_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] stage1Q;
  logic [W-1:0] stage2Q;
  logic [W-1:0] stage3Q;
  logic [W-1:0] levelQ;
  logic [W-1:0] riseQ;

  if (W < 1) begin : g_check
    $error("pin_sync3: W must be at least 1");
  end

  // Shift chain; first stage feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1Q <= '0;
      stage2Q <= '0;
      stage3Q <= '0;
    end else if (ce) begin
      stage1Q <= pinIn;
      stage2Q <= stage1Q;
      stage3Q <= stage2Q;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      levelQ <= '0;
      riseQ  <= '0;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (stage2Q[i] == stage3Q[i]) begin
          levelQ[i] <= stage3Q[i];
          riseQ[i]  <= stage3Q[i] & ~levelQ[i];
        end else begin
          riseQ[i] <= 1'b0;
        end
      end
    end
  end

  assign level = levelQ;
  assign rise  = riseQ;

endmodule

// ==== bench/pulse_gate_source.sv ====
// Far-side model: count pulse pins and the two gate pins.
// Assumes callers enter its tasks just after a rising mclk edge.
module pulse_gate_source (
  input  wire logic       mclk,
  output logic      [1:0] countPulse,
  output logic            externalGateFirst,
  output logic            externalGateSecond
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins rest low outside pulses
  initial begin
    countPulse = 2'b00;
    externalGateFirst = 1'b0;
    externalGateSecond = 1'b0;
  end

  // Five cycles each way, well past the three-flop filter
  task automatic pulse(input int idx);
    countPulse[idx] = 1'b1;
    repeat (5) @(posedge mclk);
    #1 countPulse[idx] = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  // Settle time lets the synchronised gate level catch up
  task automatic setGate(input int idx, input logic lvl);
    if (idx == 0) externalGateFirst = lvl;
    else externalGateSecond = lvl;
    repeat (8) @(posedge mclk);
    #1;
  endtask
endmodule

// ==== bench/tb_paged_dual_down_counter.sv ====
// Self-checking bench for the paged dual down-counter.
// Assumes the far-side model drives pins and a 50 MHz mclk.
module tb_paged_dual_down_counter import pdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, rst, ce, pageSel;
  bus_req_t busReq;
  logic [7:0] rdData;
  logic [1:0] countPulse;
  logic gateA, gateB;
  logic [23:0] count0Value;
  logic [15:0] count1Value;
  int errors, total_checks, cycles, k, op, lastRd;
  int m[2], stg[3], lat[3];
  bit run[2], gate[2], lvl[2];

  paged_dual_down_counter dut (.mclk(mclk), .rst(rst), .ce(ce),
    .pageSel(pageSel), .busReq(busReq), .rdData(rdData),
    .countPulse(countPulse), .externalGateFirst(gateA),
    .externalGateSecond(gateB), .count0Value(count0Value),
    .count1Value(count1Value));
  pulse_gate_source src (.mclk(mclk), .countPulse(countPulse),
    .externalGateFirst(gateA), .externalGateSecond(gateB));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // Hang guard; the whole run needs well under this
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp,
                     input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask

  task automatic checkCounts();
    chk(count0Value, 24'(m[0]), "count0");
    chk({8'h00, count1Value}, 24'(m[1]), "count1");
  endtask

  // Idle cycle after each access so strobes never re-assert in one step
  task automatic acc(input logic w, input logic r, input logic [3:0] a,
                     input logic [7:0] d);
    busReq = '{wr: w, rd: r, addr: a, data: d};
    @(posedge mclk);
    #1 busReq = '0;
    @(posedge mclk);
    #1;
  endtask

  task automatic wrStage(input int a, input int d);
    acc(1'b1, 1'b0, 4'(a), 8'(d));
    if (ce && !pageSel) stg[a-12] = d;
    checkCounts();
  endtask

  task automatic rdChk(input int a);
    acc(1'b0, 1'b1, 4'(a), 8'h00);
    if (ce) lastRd = (pageSel || a == 15) ? 0 : lat[a-12];
    chk({16'h0000, rdData}, 24'(lastRd), "read");
  endtask

  // Model of one command: one operation bit per write
  task automatic cmd(input int sel, input int op);
    logic [7:0] d;
    d = 8'(1 << op);
    d[7] = sel[0];
    acc(1'b1, 1'b0, OFF_COMMAND, d);
    if (ce && !pageSel) begin
      case (op)
        6: for (int b = 0; b < 3 - sel; b++) lat[b] = (m[sel] >> 8*b) & 255;
        5: gate[sel] = 1'b0;
        4: gate[sel] = 1'b1;
        3: run[sel] = 1'b0;
        2: run[sel] = 1'b1;
        1: m[sel] = stg[0] | stg[1] << 8 | (sel ? 0 : stg[2] << 16);
        default: m[sel] = 0;
      endcase
    end
    checkCounts();
  endtask

  task automatic pulse(input int i);
    src.pulse(i);
    if (run[i] && (!gate[i] || lvl[i]))
      m[i] = (m[i] - 1) & (i ? 32'h0000_FFFF : 32'h00FF_FFFF);
    checkCounts();
  endtask

  task automatic gateSet(input int i, input int v);
    src.setGate(i, v[0]);
    lvl[i] = v[0];
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pageSel = 1'b0;
    busReq = '0;
    k = $urandom(36598);
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    checkCounts();
    for (int a = 12; a < 16; a++) rdChk(a);
    $display("test reset done");
    // Bytes in scrambled order, then load and read back low to high
    wrStage(12, 8'h56);
    wrStage(14, 8'h12);
    wrStage(13, 8'h34);
    cmd(0, 1);
    chk(count0Value, 24'h12_3456, "walk load");
    cmd(0, 6);
    for (int a = 12; a < 15; a++) rdChk(a);
    wrStage(14, 8'hA5);
    cmd(1, 1);
    cmd(1, 6);
    for (int a = 12; a < 15; a++) rdChk(a);
    $display("test load and latch done");
    // Wrap, gating on and off, stop, for both counters
    for (int i = 0; i < 2; i++) begin
      cmd(i, 0);
      cmd(i, 2);
      pulse(i);
      cmd(i, 4);
      gateSet(i, 0);
      pulse(i);
      gateSet(i, 1);
      pulse(i);
      gateSet(i, 0);
      cmd(i, 5);
      pulse(i);
      cmd(i, 3);
      pulse(i);
    end
    $display("test counting done");
    // Hidden map: writes dropped, reads zero
    pageSel = 1'b1;
    wrStage(12, 8'hEE);
    cmd(0, 1);
    rdChk(12);
    pageSel = 1'b0;
    rdChk(12);
    $display("test page done");
    // Random mix; ce and page occasionally drop on bus accesses
    repeat (400) begin
      op = $urandom % 5;
      if (op != 2 && op != 4) begin
        ce = ($urandom % 6) != 0;
        pageSel = ($urandom % 8) == 0;
      end
      case (op)
        0: wrStage(12 + $urandom % 3, $urandom % 256);
        1: cmd($urandom % 2, $urandom % 7);
        2: pulse($urandom % 2);
        3: rdChk(12 + $urandom % 4);
        default: gateSet($urandom % 2, $urandom % 2);
      endcase
      ce = 1'b1;
      pageSel = 1'b0;
    end
    $display("test random done");
    close_out();
  end
endmodule
